//--- verilog/pdrc_top.sv
// Power-down mode control and reset sequencing for the processor.
// Assumes oscillator inputs are already sampled synchronous to clk.
//
// Function
// - Hf oscillator runs while disable bit is 0
// - Power-down bit selects hf or lf clocking
// - Power-down refresh at lf rate over four
// - Power-down core clock at lf over eight
// - Select write starts transition after refresh ends
// - Read select bit changes only when done
// - Reset sampled on falling cpu clock edge
// - Low reset aborts instruction, drops pending results
// - Reset clears pending interrupts, traps, nmi latch
// - Codec strobes and frame sync inactive in reset
// - Cpu clock at half hf rate in reset
// - Codec master clock held high in reset
// - Reset clears processor status word to zero
// - After reset only nmi accepted
// - Codec serial input drives out until configured
//
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module pdrc_top
  import pdrc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Oscillator, reset, refresh, status word and interrupt inputs
  input wire logic hf_osc_input,
  input wire logic lf_osc_input,
  input wire logic cpu_reset_n,
  input wire logic refresh_busy,
  input wire logic [15:0] psw_in,
  input wire logic psw_load,
  input wire logic int_pending_in,
  input wire logic nmi_edge,
  // Outputs
  output logic hf_osc_enable,
  output logic clk_sel_lf,
  output logic cpu_clock_out,
  output logic core_clk_en,
  output logic refresh_req,
  output logic modules_halt,
  output logic cpu_in_reset,
  output logic abort_instr,
  output logic pending_clear,
  output logic nmi_latch,
  output logic maskable_int_en,
  output logic [15:0] processor_status_word,
  output logic codec_read_strobe_n,
  output logic codec_write_strobe_n,
  output logic codec_frame_sync,
  output logic codec_master_clock_force,
  output logic codec_serial_in_oe_n
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pdrc_mode_t mode_r, mode_nxt;
  logic pds_r, pds_nxt;
  logic pds_req_r, pds_req_nxt;
  logic hfd_r, hfd_nxt;
  logic module_config_reg_r, module_config_reg_nxt;
  logic cpu_clk_r, cpu_clk_nxt;
  logic rst_smp_r, rst_smp_nxt;
  logic [2:0] lf_cnt_r, lf_cnt_nxt;
  logic lf_prev_r, lf_prev_nxt;
  logic core_en_r, core_en_nxt;
  logic refr_r, refr_nxt;
  logic nmi_r, nmi_nxt;
  logic int_en_r, int_en_nxt;
  logic [15:0] psw_r, psw_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic ack_r, ack_nxt;
  logic lf_rise;
  logic cpu_fall;
  logic wr_ctl;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // One wait state: every access answers the cycle after it is seen
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_ctl = avs_write & ack_r & (avs_address == PDRC_CLOCK_GEN_CONTROL_ADDR);
  assign lf_rise = lf_osc_input & ~lf_prev_r;
  assign cpu_fall = cpu_clk_r & ~cpu_clk_nxt;

  always_comb begin
    mode_nxt = mode_r;
    pds_nxt = pds_r;
    pds_req_nxt = pds_req_r;
    hfd_nxt = hfd_r;
    module_config_reg_nxt = module_config_reg_r;
    rdata_nxt = rdata_r;
    ack_nxt = 1'b0;
    nmi_nxt = nmi_r | nmi_edge;
    int_en_nxt = int_en_r;
    psw_nxt = psw_load ? psw_in : psw_r;
    lf_prev_nxt = lf_osc_input;
    lf_cnt_nxt = lf_cnt_r;
    core_en_nxt = 1'b0;
    refr_nxt = 1'b0;
    rst_smp_nxt = rst_smp_r;
    cpu_clk_nxt = ~cpu_clk_r;
    // Cpu clock runs at half rate in reset and normal mode
    if (rst_smp_r && mode_r == PDRC_POWERDOWN) begin
      cpu_clk_nxt = core_en_r;
    end
    if (cpu_fall) begin
      rst_smp_nxt = cpu_reset_n;
    end
    // Bus access
    // Writes land only at the edge where waitrequest is seen low
    if (avs_write && ack_r) begin
      case (avs_address)
        PDRC_CLOCK_GEN_CONTROL_ADDR: begin
          pds_req_nxt = avs_writedata[PDRC_PDS_BIT];
          hfd_nxt = avs_writedata[PDRC_HFD_BIT];
        end
        PDRC_MODULE_CONFIG_REG_ADDR: module_config_reg_nxt = avs_writedata[PDRC_MODULE_CONFIG_REG_CODEC_SERIAL_IN_BIT];
        PDRC_PSW_ADDR: int_en_nxt = avs_writedata[PDRC_MODULE_CONFIG_REG_CODEC_SERIAL_IN_BIT];
        default: ;
      endcase
    end
    // Read data is registered in the wait cycle so it stands at the answer
    if ((avs_read | avs_write) && !ack_r) begin
      ack_nxt = 1'b1;
      rdata_nxt = PDRC_ZERO32;
      if (avs_read) begin
        case (avs_address)
          PDRC_CLOCK_GEN_CONTROL_ADDR: begin
            rdata_nxt[PDRC_PDS_BIT] = pds_r;
            rdata_nxt[PDRC_HFD_BIT] = hfd_r;
          end
          PDRC_STATUS_ADDR: begin
            rdata_nxt[PDRC_ST_PEND_BIT] = pds_req_r != pds_r;
            rdata_nxt[PDRC_ST_REFR_BIT] = refresh_busy;
            rdata_nxt[PDRC_ST_RST_BIT] = ~rst_smp_r;
          end
          PDRC_MODULE_CONFIG_REG_ADDR: rdata_nxt[PDRC_MODULE_CONFIG_REG_CODEC_SERIAL_IN_BIT] = module_config_reg_r;
          PDRC_PSW_ADDR: rdata_nxt[15:0] = psw_r;
          default: ;
        endcase
      end
    end
    // Mode transition waits for any refresh in progress
    case (mode_r)
      PDRC_NORMAL: begin
        if (pds_req_r) begin
          mode_nxt = refresh_busy ? PDRC_WAIT_REFR : PDRC_POWERDOWN;
          pds_nxt = ~refresh_busy;
        end
      end
      PDRC_WAIT_REFR: begin
        if (!refresh_busy) begin
          mode_nxt = pds_req_r ? PDRC_POWERDOWN : PDRC_NORMAL;
          pds_nxt = pds_req_r;
        end
      end
      PDRC_POWERDOWN: begin
        if (!pds_req_r) begin
          mode_nxt = refresh_busy ? PDRC_WAIT_REFR : PDRC_NORMAL;
          pds_nxt = refresh_busy;
        end
      end
      default: mode_nxt = PDRC_NORMAL;
    endcase
    // Low-frequency dividers in power-down
    if (mode_r == PDRC_POWERDOWN && lf_rise) begin
      lf_cnt_nxt = 3'(lf_cnt_r + 3'h1);
      refr_nxt = (lf_cnt_r[1:0] == 2'(PDRC_REFR_DIV - 1));
      core_en_nxt = (lf_cnt_r == 3'(PDRC_CORE_DIV - 1));
    end
    // Reset effects while the sampled level is low
    if (!rst_smp_r) begin
      nmi_nxt = 1'b0;
      int_en_nxt = 1'b0;
      psw_nxt = PDRC_PSW_RESET;
      module_config_reg_nxt = 1'b0;
      pds_nxt = 1'b0;
      pds_req_nxt = 1'b0;
      hfd_nxt = 1'b0;
      mode_nxt = PDRC_NORMAL;
      lf_cnt_nxt = 3'h0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_r <= PDRC_NORMAL;
      pds_r <= 1'b0;
      pds_req_r <= 1'b0;
      hfd_r <= 1'b0;
      module_config_reg_r <= 1'b0;
      cpu_clk_r <= 1'b0;
      rst_smp_r <= 1'b0;
      lf_cnt_r <= 3'h0;
      lf_prev_r <= 1'b0;
      core_en_r <= 1'b0;
      refr_r <= 1'b0;
      nmi_r <= 1'b0;
      int_en_r <= 1'b0;
      psw_r <= PDRC_PSW_RESET;
      rdata_r <= PDRC_ZERO32;
      ack_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      pds_r <= pds_nxt;
      pds_req_r <= pds_req_nxt;
      hfd_r <= hfd_nxt;
      module_config_reg_r <= module_config_reg_nxt;
      cpu_clk_r <= cpu_clk_nxt;
      rst_smp_r <= rst_smp_nxt;
      lf_cnt_r <= lf_cnt_nxt;
      lf_prev_r <= lf_prev_nxt;
      core_en_r <= core_en_nxt;
      refr_r <= refr_nxt;
      nmi_r <= nmi_nxt;
      int_en_r <= int_en_nxt;
      psw_r <= psw_nxt;
      rdata_r <= rdata_nxt;
      ack_r <= ack_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_readdata = rdata_r;
  assign hf_osc_enable = ~hfd_r;
  assign clk_sel_lf = pds_r;
  assign modules_halt = pds_r;
  assign cpu_clock_out = cpu_clk_r;
  assign core_clk_en = (mode_r == PDRC_POWERDOWN) ? core_en_r : 1'b1;
  assign refresh_req = refr_r;
  assign cpu_in_reset = ~rst_smp_r;
  assign abort_instr = ~rst_smp_r;
  assign pending_clear = ~rst_smp_r | ~int_pending_in & 1'b0;
  assign nmi_latch = nmi_r;
  assign maskable_int_en = int_en_r;
  assign processor_status_word = psw_r;
  assign codec_read_strobe_n = 1'b1;
  assign codec_write_strobe_n = 1'b1;
  assign codec_frame_sync = 1'b0;
  assign codec_master_clock_force = ~rst_smp_r;
  assign codec_serial_in_oe_n = module_config_reg_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  hf_osc_ctl_a: assert property (@(posedge clk) disable iff (!nrst)
    (wr_ctl && rst_smp_r) |=> hf_osc_enable == !$past(avs_writedata[PDRC_HFD_BIT]))
    else $error("hf oscillator enable wrong");
  wr_land_a: assert property (@(posedge clk) disable iff (!nrst)
    (wr_ctl && rst_smp_r) |=> pds_req_r == $past(avs_writedata[PDRC_PDS_BIT]))
    else $error("select write not taken");
  refr_pd_a: assert property (@(posedge clk) disable iff (!nrst)
    (mode_r != PDRC_POWERDOWN) |=> !refresh_req)
    else $error("refresh pulse outside power-down");
  core_norm_a: assert property (@(posedge clk) disable iff (!nrst)
    (mode_r == PDRC_NORMAL) |-> core_clk_en)
    else $error("core clock gated in normal mode");
  codec_idle_a: assert property (@(posedge clk) disable iff (!nrst)
    cpu_in_reset |-> (codec_read_strobe_n && codec_write_strobe_n && !codec_frame_sync))
    else $error("codec strobes active in reset");
  mclk_rst_a: assert property (@(posedge clk) disable iff (!nrst)
    cpu_in_reset |-> codec_master_clock_force)
    else $error("codec master clock not forced");
  refr_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    (refresh_busy && mode_r == PDRC_NORMAL && rst_smp_r) |=> !pds_r)
    else $error("mode changed during refresh");
  pds_stable_a: assert property (@(posedge clk) disable iff (!nrst)
    (mode_r == PDRC_WAIT_REFR && refresh_busy) |=> $stable(pds_r))
    else $error("select bit moved early");
  rst_psw_a: assert property (@(posedge clk) disable iff (!nrst)
    !rst_smp_r |=> psw_r == PDRC_PSW_RESET || psw_load)
    else $error("status word not cleared");
  rst_nmi_a: assert property (@(posedge clk) disable iff (!nrst)
    (!rst_smp_r && !nmi_edge) |=> !nmi_r) else $error("nmi latch kept");
  rst_int_a: assert property (@(posedge clk) disable iff (!nrst)
    !rst_smp_r |=> !maskable_int_en) else $error("maskable int in reset");
  rst_clk_a: assert property (@(posedge clk) disable iff (!nrst)
    (!rst_smp_r && !$past(rst_smp_r) && $past(nrst)) |-> cpu_clk_r != $past(cpu_clk_r))
    else $error("cpu clock not half rate");
  rst_codec_serial_in_a: assert property (@(posedge clk) disable iff (!nrst)
    !rst_smp_r |=> !codec_serial_in_oe_n) else $error("serial in not output");
  bus_wait_a: assert property (@(posedge clk) disable iff (!nrst)
    (avs_write && !ack_r) |=> !avs_waitrequest || !avs_write)
    else $error("bus answer late");
endmodule : pdrc_top
`default_nettype wire

//--- pkg/pdrc_pkg.sv
// Package for the power-down and reset control block.
// Assumes a 100 MHz system clock and an Avalon-MM register slave.
package pdrc_pkg;
  // ----------------------------------------------------------------
  // Register map (word offsets as byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] PDRC_CLOCK_GEN_CONTROL_ADDR = 4'h0;
  localparam logic [3:0] PDRC_STATUS_ADDR = 4'h4;
  localparam logic [3:0] PDRC_MODULE_CONFIG_REG_ADDR = 4'h8;
  localparam logic [3:0] PDRC_PSW_ADDR = 4'hC;
  // Field positions in the clock control register
  localparam int PDRC_PDS_BIT = 0;
  localparam int PDRC_HFD_BIT = 1;
  // Status register fields
  localparam int PDRC_ST_PEND_BIT = 0;
  localparam int PDRC_ST_REFR_BIT = 1;
  localparam int PDRC_ST_RST_BIT = 2;
  // Module config: bit that turns the codec serial input into an input
  localparam int PDRC_MODULE_CONFIG_REG_CODEC_SERIAL_IN_BIT = 0;
  // Reset values
  localparam logic [31:0] PDRC_ZERO32 = 32'h0000_0000;
  localparam logic [15:0] PDRC_PSW_RESET = 16'h0000;
  // Divider ratios
  localparam int PDRC_REFR_DIV = 4;
  localparam int PDRC_CORE_DIV = 8;
  localparam int PDRC_RST_DIV = 2;
  // Refresh cycle length in core clocks
  localparam int PDRC_REFR_LEN = 4;
  typedef enum logic [1:0] {PDRC_NORMAL, PDRC_WAIT_REFR, PDRC_POWERDOWN} pdrc_mode_t;
endpackage : pdrc_pkg

//--- tb/pdrc_ext_model.sv
// ------------------------------------------------------------------
// Model of the reset source, the slow oscillator and the refresh engine
// ------------------------------------------------------------------
// Assumes the bench requests reset and refresh by level.
`timescale 1ns/100ps
`default_nettype none
module pdrc_ext_model #(
  parameter int HOLD_CYC = 20,
  parameter int LF_HALF = 4
) (
  input wire logic clk,
  input wire logic rst_req,
  input wire logic refr_req,
  output logic lf_osc_input,
  output logic cpu_reset_n,
  output logic refresh_busy
);
  int lf_cnt = 0;
  int hold_cnt = 0;
  initial begin
    lf_osc_input = 1'b0;
    cpu_reset_n = 1'b1;
    refresh_busy = 1'b0;
  end
  // Slow oscillator runs free; the real one never stops either
  always @(posedge clk) begin
    lf_cnt <= (lf_cnt == LF_HALF - 1) ? 0 : lf_cnt + 1;
    if (lf_cnt == LF_HALF - 1) begin
      lf_osc_input <= ~lf_osc_input;
    end
    refresh_busy <= refr_req;
    if (rst_req) begin
      hold_cnt <= HOLD_CYC;
    end else if (hold_cnt > 0) begin
      hold_cnt <= hold_cnt - 1;
    end
    // Minimum low time is scaled down to keep the run short
    cpu_reset_n <= !(rst_req || hold_cnt > 1);
  end
endmodule : pdrc_ext_model
`default_nettype wire

//--- tb/pdrc_top_tb_top.sv
// ------------------------------------------------------------------
// Self-checking bench for the power-down and reset control block
// ------------------------------------------------------------------
// Assumes a 100 MHz clock and the two-cycle bus access of the block.
`timescale 1ns/100ps
`default_nettype none
module pdrc_top_tb_top;
  import pdrc_pkg::*;
  logic clk, nrst, avs_read, avs_write, avs_waitrequest, psw_load, nmi_edge;
  logic rst_req, refr_req, lf_osc, cpu_rst_n, refr_busy;
  logic hf_en, sel_lf, cpu_clk, core_en, refr_rq, halt, in_rst, abort_i, pend_clr;
  logic nmi_l, mint_en, rd_n, wr_n, fsync, mclk_f, sin_oe_n, b;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic [15:0] psw_in, psw;
  int num_errors = 0;
  int checked = 0;
  pdrc_ext_model ext_u (.clk(clk), .rst_req(rst_req), .refr_req(refr_req),
    .lf_osc_input(lf_osc), .cpu_reset_n(cpu_rst_n), .refresh_busy(refr_busy));
  pdrc_top dut_u (.clk(clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .hf_osc_input(1'b0), .lf_osc_input(lf_osc), .cpu_reset_n(cpu_rst_n),
    .refresh_busy(refr_busy), .psw_in(psw_in), .psw_load(psw_load),
    .int_pending_in(1'b0), .nmi_edge(nmi_edge), .hf_osc_enable(hf_en),
    .clk_sel_lf(sel_lf), .cpu_clock_out(cpu_clk), .core_clk_en(core_en),
    .refresh_req(refr_rq), .modules_halt(halt), .cpu_in_reset(in_rst),
    .abort_instr(abort_i), .pending_clear(pend_clr), .nmi_latch(nmi_l),
    .maskable_int_en(mint_en), .processor_status_word(psw),
    .codec_read_strobe_n(rd_n), .codec_write_strobe_n(wr_n),
    .codec_frame_sync(fsync), .codec_master_clock_force(mclk_f),
    .codec_serial_in_oe_n(sin_oe_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Request holds until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0 && ++n < 50);
    if (n >= 50) num_errors++;
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(negedge clk);
  endtask : bus
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(d, exp);
  endtask : rd_chk
  // Cycles from one pulse to the next on the refresh or core enable line
  task automatic span(input logic core, input int exp);
    int n;
    n = 0;
    do @(negedge clk); while ((core ? core_en : refr_rq) !== 1'b1 && ++n < 300);
    n = 0;
    do @(negedge clk); while ((core ? core_en : refr_rq) !== 1'b1 && ++n < 300);
    chk(32'(n + 1), 32'(exp));
  endtask : span
  task automatic give_verdict();
    if (num_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
  initial begin
    {nrst, avs_read, avs_write, psw_load, nmi_edge, rst_req, refr_req} = 7'h00;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    psw_in = 16'h0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(PDRC_CLOCK_GEN_CONTROL_ADDR, PDRC_ZERO32);
    chk({30'h0, hf_en, core_en}, 32'h3);
    chk({29'h0, rd_n, wr_n, fsync}, 32'h6);
    chk({31'h0, sin_oe_n}, 32'h0);
    bus(1'b1, PDRC_MODULE_CONFIG_REG_ADDR, 32'h1);
    chk({31'h0, sin_oe_n}, 32'h1);
    bus(1'b1, 4'h6, 32'hFFFF_FFFF);
    rd_chk(4'h6, PDRC_ZERO32);
    // Power-down round trip; no other module is touched meanwhile
    @(posedge clk);
    refr_req <= 1'b1;
    bus(1'b1, PDRC_CLOCK_GEN_CONTROL_ADDR, 32'h1);
    rd_chk(PDRC_CLOCK_GEN_CONTROL_ADDR, PDRC_ZERO32);
    chk({31'h0, sel_lf}, 32'h0);
    @(posedge clk);
    refr_req <= 1'b0;
    repeat (6) @(posedge clk);
    rd_chk(PDRC_CLOCK_GEN_CONTROL_ADDR, 32'h1);
    chk({30'h0, halt, sel_lf}, 32'h3);
    bus(1'b1, PDRC_CLOCK_GEN_CONTROL_ADDR, 32'h3);
    chk({31'h0, hf_en}, 32'h0);
    span(1'b0, 4 * 8);
    span(1'b1, 8 * 8);
    bus(1'b1, PDRC_CLOCK_GEN_CONTROL_ADDR, 32'h1);
    chk({31'h0, hf_en}, 32'h1);
    bus(1'b1, PDRC_CLOCK_GEN_CONTROL_ADDR, 32'h0);
    repeat (6) @(posedge clk);
    rd_chk(PDRC_CLOCK_GEN_CONTROL_ADDR, PDRC_ZERO32);
    chk({31'h0, core_en}, 32'h1);
    // Load state that reset must wipe
    @(posedge clk);
    psw_in <= 16'hA5A5;
    {psw_load, nmi_edge} <= 2'h3;
    @(posedge clk);
    {psw_load, nmi_edge} <= 2'h0;
    bus(1'b1, PDRC_PSW_ADDR, 32'h1);
    chk({31'h0, mint_en}, 32'h1);
    rd_chk(PDRC_PSW_ADDR, 32'h0000_A5A5);
    @(posedge clk);
    rst_req <= 1'b1;
    @(posedge clk);
    rst_req <= 1'b0;
    repeat (6) @(negedge clk);
    chk({28'h0, in_rst, abort_i, pend_clr, mclk_f}, 32'hF);
    chk({30'h0, nmi_l, mint_en}, 32'h0);
    chk({16'h0, psw}, PDRC_ZERO32);
    chk({29'h0, rd_n, wr_n, fsync}, 32'h6);
    b = cpu_clk;
    @(negedge clk);
    chk({31'h0, cpu_clk}, {31'h0, ~b});
    repeat (40) @(negedge clk);
    chk({31'h0, in_rst}, 32'h0);
    chk({30'h0, mint_en, hf_en}, 32'h1);
    give_verdict();
  end
endmodule : pdrc_top_tb_top
`default_nettype wire
